//--- hdl/gpa_port.v
// eight-bit general-purpose port with shared analog, comparator and clock pins
//
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "gpa_regs.vh"
module gpa_port
#(
   parameter PINS = 8
)
(
   input wire clk,
   input wire resetn,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   input wire comparator_one_output,
   input wire comparator_two_output,
   input wire [PINS-1:0] pad_in,
   output reg [PINS-1:0] pad_out,
   output reg [PINS-1:0] pad_oe,
   output reg [PINS-1:0] analog_sel
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   reg [PINS-1:0] port_latch_bits_ff;
   reg [PINS-1:0] port_direction_bits_ff;
   reg [`GPA_ANCFG_W-1:0] analog_pin_config_ff;
   reg [5:0] comparator_control_ff;
   reg [7:0] comparator_reference_control_ff;
   reg [3:0] osc_config_ff;
   reg [1:0] cyc_div_ff;
   reg cycle_clock_output_ff;

   wire wb_req;
   wire wr_en;
   wire [2:0] cmp_mode;
   wire cmp_on;
   wire cvr_oe;
   wire pin6_io;
   wire pin6_cycle_clock_output;
   wire pin7_io;
   wire [PINS-1:0] io_mask;
   wire [PINS-1:0] an_en;
   wire [PINS-1:0] kill_in;
   wire [PINS-1:0] kill_out;
   wire [PINS-1:0] force_oe;
   wire [PINS-1:0] ovr_en;
   wire [PINS-1:0] ovr_val;
   wire [PINS-1:0] nxt_pad_out;
   wire [PINS-1:0] nxt_pad_oe;
   wire [PINS-1:0] pin_read;
   reg [31:0] nxt_rd_data;

   // ----------------------------------------
   // analog channel decode
   // ----------------------------------------
   // a channel is analog while pcfg plus its channel number stays within the limit
   function chan_analog;
      input [3:0] pcfg;
      input [3:0] chan;
      reg [4:0] sum;
      begin
         sum = {1'b0, pcfg} + {1'b0, chan};
         chan_analog = (sum <= {1'b0, `GPA_PCFG_LIMIT});
      end
   endfunction

   // ----------------------------------------
   // oscillator pin ownership
   // ----------------------------------------
   assign pin6_io = (osc_config_ff == `GPA_OSC_RC_OSCILLATOR_WITH_IO) | (osc_config_ff == `GPA_OSC_INT_IO) |
      (osc_config_ff == `GPA_OSC_EXTERNAL_CLOCK_WITH_IO);
   assign pin6_cycle_clock_output = (osc_config_ff == `GPA_OSC_RC) | (osc_config_ff == `GPA_OSC_INT_CYCLE_CLOCK_OUTPUT) |
      (osc_config_ff == `GPA_OSC_EC);
   assign pin7_io = (osc_config_ff == `GPA_OSC_INT_IO) | (osc_config_ff == `GPA_OSC_INT_CYCLE_CLOCK_OUTPUT);
   assign io_mask = {pin7_io, pin6_io, 6'h3f};

   // ----------------------------------------
   // analog and comparator selection
   // ----------------------------------------
   assign cmp_mode = comparator_control_ff[`GPA_CMP_MODE_MSB:0];
   assign cmp_on = (cmp_mode != `GPA_CMP_OFF);
   assign cvr_oe = comparator_reference_control_ff[`GPA_CVR_OE_BIT];

   // comparators running also claim pins 0-3 as analog inputs
   assign an_en[0] = chan_analog(analog_pin_config_ff[`GPA_PCFG_MSB:0], 4'h0) | cmp_on;
   assign an_en[1] = chan_analog(analog_pin_config_ff[`GPA_PCFG_MSB:0], 4'h1) | cmp_on;
   assign an_en[2] = chan_analog(analog_pin_config_ff[`GPA_PCFG_MSB:0], 4'h2) | cmp_on;
   assign an_en[3] = chan_analog(analog_pin_config_ff[`GPA_PCFG_MSB:0], 4'h3) | cmp_on;
   assign an_en[4] = 1'b0;
   assign an_en[5] = chan_analog(analog_pin_config_ff[`GPA_PCFG_MSB:0], 4'h4);
   assign an_en[6] = 1'b0;
   assign an_en[7] = 1'b0;

   // ----------------------------------------
   // per-pin overrides
   // ----------------------------------------
   assign kill_in = an_en | {~pin7_io, ~pin6_io, 3'h0, cvr_oe, 2'h0};
   assign kill_out = {~pin7_io, ~pin6_io & ~pin6_cycle_clock_output, 3'h0, cvr_oe, 2'h0};
   assign force_oe = {1'b0, pin6_cycle_clock_output, 6'h00};
   assign ovr_en[0] = 1'b0;
   assign ovr_en[1] = 1'b0;
   assign ovr_en[2] = 1'b0;
   assign ovr_en[3] = 1'b0;
   assign ovr_en[4] = (cmp_mode == `GPA_CMP_BOTH_OUT);
   assign ovr_en[5] = (cmp_mode == `GPA_CMP_BOTH_OUT) | (cmp_mode == `GPA_CMP_TWO_OUT);
   assign ovr_en[6] = pin6_cycle_clock_output;
   assign ovr_en[7] = 1'b0;
   assign ovr_val = {1'b0, cycle_clock_output_ff, comparator_two_output, comparator_one_output, 4'h0};

   // ----------------------------------------
   // pin muxes
   // ----------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < PINS; gi = gi + 1)
      begin : g_pin
         gpa_pin_mux u_mux
         (
            .dir(port_direction_bits_ff[gi]),
            .lat(port_latch_bits_ff[gi]),
            .ovr_en(ovr_en[gi]),
            .ovr_val(ovr_val[gi]),
            .force_oe(force_oe[gi]),
            .kill_out(kill_out[gi]),
            .kill_in(kill_in[gi]),
            .pad_level(pad_in[gi]),
            .nxt_out(nxt_pad_out[gi]),
            .nxt_oe(nxt_pad_oe[gi]),
            .rd_level(pin_read[gi])
         );
      end
   endgenerate

   // ----------------------------------------
   // pad registers and cycle clock divider
   // ----------------------------------------
   // pads lag the registers by one edge so every output is a flip-flop
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pad_out <= 8'h00;
         pad_oe <= 8'h00;
         analog_sel <= 8'h00;
         cyc_div_ff <= 2'h0;
         cycle_clock_output_ff <= 1'b0;
      end
      else
      begin
         pad_out <= nxt_pad_out;
         pad_oe <= nxt_pad_oe;
         analog_sel <= an_en;
         cyc_div_ff <= cyc_div_ff + 2'h1;
         // high for two cycles, low for two: a quarter of the system clock
         cycle_clock_output_ff <= cyc_div_ff[1];
      end
   end

   // ----------------------------------------
   // wishbone slave
   // ----------------------------------------
   // single-cycle answer; the master holds the request, so ack is dropped a cycle later
   assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_en = wb_req & wb_we_i & wb_sel_i[0];

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   // one decode feeds both the read mux and the write strobes, so they cannot disagree on the map
   // unmapped offsets hit nothing: they are still acked, read 0 and drop writes
   wire hit_port;
   wire hit_latch;
   wire hit_dir;
   wire hit_ancfg;
   wire hit_cmpctl;
   wire hit_cvrctl;
   wire hit_osccfg;

   assign hit_port = (wb_adr_i == `GPA_OFS_PORT);
   assign hit_latch = (wb_adr_i == `GPA_OFS_LATCH);
   assign hit_dir = (wb_adr_i == `GPA_OFS_DIR);
   assign hit_ancfg = (wb_adr_i == `GPA_OFS_ANCFG);
   assign hit_cmpctl = (wb_adr_i == `GPA_OFS_CMPCTL);
   assign hit_cvrctl = (wb_adr_i == `GPA_OFS_CVRCTL);
   assign hit_osccfg = (wb_adr_i == `GPA_OFS_OSCCFG);

   always @*
   begin
      nxt_rd_data = 32'h00000000;
      if (hit_port)
      begin
         nxt_rd_data[7:0] = pin_read & io_mask;
      end
      else if (hit_latch)
      begin
         nxt_rd_data[7:0] = port_latch_bits_ff & io_mask;
      end
      else if (hit_dir)
      begin
         nxt_rd_data[7:0] = port_direction_bits_ff & io_mask;
      end
      else if (hit_ancfg)
      begin
         nxt_rd_data[7:0] = {2'h0, analog_pin_config_ff};
      end
      else if (hit_cmpctl)
      begin
         nxt_rd_data[7:0] = {comparator_two_output, comparator_one_output, comparator_control_ff};
      end
      else if (hit_cvrctl)
      begin
         nxt_rd_data[7:0] = comparator_reference_control_ff;
      end
      else if (hit_osccfg)
      begin
         nxt_rd_data[3:0] = osc_config_ff;
      end
   end

   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= wb_req;
         wb_dat_o <= wb_req ? nxt_rd_data : 32'h00000000;
      end
   end

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         port_latch_bits_ff <= `GPA_RST_LATCH;
         port_direction_bits_ff <= `GPA_RST_DIR;
         analog_pin_config_ff <= `GPA_RST_ANCFG;
         comparator_control_ff <= `GPA_RST_CMPCTL;
         comparator_reference_control_ff <= `GPA_RST_CVRCTL;
         osc_config_ff <= `GPA_RST_OSCCFG;
      end
      else if (wr_en)
      begin
         // port and latch offsets both land in the latch
         if (hit_port || hit_latch)
         begin
            port_latch_bits_ff <= wb_dat_i[7:0];
         end
         else if (hit_dir)
         begin
            port_direction_bits_ff <= wb_dat_i[7:0];
         end
         else if (hit_ancfg)
         begin
            analog_pin_config_ff <= wb_dat_i[`GPA_ANCFG_W-1:0];
         end
         else if (hit_cmpctl)
         begin
            comparator_control_ff <= wb_dat_i[5:0];
         end
         else if (hit_cvrctl)
         begin
            comparator_reference_control_ff <= wb_dat_i[7:0];
         end
         else if (hit_osccfg)
         begin
            osc_config_ff <= wb_dat_i[3:0];
         end
      end
   end

endmodule

//--- hdl/gpa_regs.vh
// register map, field positions, reset values and codes of the port block
`ifndef GPA_REGS_VH
`define GPA_REGS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define GPA_OFS_PORT 8'h00
`define GPA_OFS_LATCH 8'h04
`define GPA_OFS_DIR 8'h08
`define GPA_OFS_ANCFG 8'h0c
`define GPA_OFS_CMPCTL 8'h10
`define GPA_OFS_CVRCTL 8'h14
`define GPA_OFS_OSCCFG 8'h18

// ----------------------------------------
// reset values
// ----------------------------------------
`define GPA_RST_LATCH 8'h00
`define GPA_RST_DIR 8'hff
`define GPA_RST_ANCFG 6'h00
`define GPA_RST_CMPCTL 6'h07
`define GPA_RST_CVRCTL 8'h00
`define GPA_RST_OSCCFG 4'h6

// ----------------------------------------
// field positions
// ----------------------------------------
`define GPA_ANCFG_W 6
`define GPA_PCFG_MSB 3
`define GPA_CMP_MODE_MSB 2
`define GPA_CMP_ONE_OUT_BIT 6
`define GPA_CMP_TWO_OUT_BIT 7
`define GPA_CVR_OE_BIT 6

// ----------------------------------------
// comparator modes and analog channel decode
// ----------------------------------------
`define GPA_CMP_OFF 3'h7
`define GPA_CMP_BOTH_OUT 3'h3
`define GPA_CMP_TWO_OUT 3'h5
`define GPA_PCFG_LIMIT 4'he

// ----------------------------------------
// oscillator configuration codes
// ----------------------------------------
`define GPA_OSC_LP 4'h0
`define GPA_OSC_XT 4'h1
`define GPA_OSC_HS 4'h2
`define GPA_OSC_RC 4'h3
`define GPA_OSC_RC_OSCILLATOR_WITH_IO 4'h4
`define GPA_OSC_INT_CYCLE_CLOCK_OUTPUT 4'h5
`define GPA_OSC_INT_IO 4'h6
`define GPA_OSC_EC 4'h7
`define GPA_OSC_EXTERNAL_CLOCK_WITH_IO 4'h8

`endif

//--- hdl/gpa_pin_mux.v
// one port pin: output select, driver enable and digital input gate
`timescale 1ns/1ns
module gpa_pin_mux
(
   input wire dir,
   input wire lat,
   input wire ovr_en,
   input wire ovr_val,
   input wire force_oe,
   input wire kill_out,
   input wire kill_in,
   input wire pad_level,
   output wire nxt_out,
   output wire nxt_oe,
   output wire rd_level
);

   // ----------------------------------------
   // output path
   // ----------------------------------------
   // analog selection is deliberately absent here: it never touches the output
   assign nxt_out = ovr_en ? ovr_val : lat;
   assign nxt_oe = ~kill_out & (force_oe | ~dir);

   // ----------------------------------------
   // input path
   // ----------------------------------------
   // gated input reads 0 so a floating analog level cannot toggle logic
   assign rd_level = pad_level & ~kill_in;

endmodule

//--- tb/gpa_port_monitor.sv
// assertion checker of the port block, bound into its top
`timescale 1ns/1ns
`include "gpa_regs.vh"
module gpa_port_monitor
#(
   parameter PINS = 8
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic comparator_one_output,
   input wire logic comparator_two_output,
   input wire logic [PINS-1:0] pad_in,
   input wire logic [PINS-1:0] pad_out,
   input wire logic [PINS-1:0] pad_oe,
   input wire logic [PINS-1:0] analog_sel
);
// ----------------
// bus and pin properties
// ----------------
wire wr_ack = wb_ack_o & wb_we_i & wb_sel_i[0];
default clocking cb @(posedge clk);
endclocking
default disable iff (!resetn);
sequence s_req;
   wb_cyc_i && wb_stb_i && !wb_ack_o;
endsequence
sequence s_port_rd;
   wb_ack_o && !wb_we_i && wb_adr_i == `GPA_OFS_PORT;
endsequence
a_ack_on_time: assert property (s_req |=> wb_ack_o)
   else $error("request not acknowledged");
a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
   else $error("acknowledge too long");
a_idle_data_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
   else $error("data outside acknowledge");
a_upper_bits_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
   else $error("data above byte lane");
a_ancfg_top_zero: assert property (wb_ack_o && !wb_we_i
   && wb_adr_i == `GPA_OFS_ANCFG |-> wb_dat_o[7:6] == 2'h0)
   else $error("analog config top bits set");
a_analog_reads_zero: assert property (s_port_rd
   |-> (wb_dat_o[5:0] & analog_sel[5:0]) == 6'h0)
   else $error("analog pin read not zero");
a_pin_level_read: assert property (s_port_rd |-> wb_dat_o[4] == $past(pad_in[4]))
   else $error("pin four level not read");
a_pads_need_write: assert property ($changed(pad_out[3:0]) || $changed(pad_oe[3:0])
   |-> $past(wr_ack))
   else $error("pad change without write");
endmodule

bind gpa_port gpa_port_monitor #(.PINS(PINS)) mon_u (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .comparator_one_output(comparator_one_output),
   .comparator_two_output(comparator_two_output), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
   .analog_sel(analog_sel));

//--- tb/gpa_port_tb.sv
// self-checking bench of the port block against a register model
`timescale 1ns/1ns
`include "gpa_regs.vh"
module gpa_port_tb;
reg clk = 1'b0, resetn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
reg comparator_one_output = 1'b0, comparator_two_output = 1'b0;
reg [7:0] wb_adr_i = 8'h00, pad_in = 8'h00, ext = 8'h5a, io, e_oe, e_out, e_an, ck, cs;
reg [3:0] wb_sel_i = 4'h0;
reg [31:0] wb_dat_i = 32'h0, rd, d;
wire [31:0] wb_dat_o;
wire wb_ack_o;
wire [7:0] pad_out, pad_oe, analog_sel;
integer fails = 0, compares = 0, cycles = 0, i, j, m_lat, m_dir, m_anc, m_cmp, m_cvr, m_osc;
gpa_port #(.PINS(8)) dut_u (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .comparator_one_output(comparator_one_output),
   .comparator_two_output(comparator_two_output), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
   .analog_sel(analog_sel));
initial forever #5 clk = ~clk;
// ----------------
// pins, timeout and tasks
// ----------------
// driven pins read back their own level, floating ones a random outside level
always @(posedge clk)
   pad_in <= (pad_oe & pad_out) | (~pad_oe & ext);
always @(posedge clk)
begin
   cycles = cycles + 1;
   if (cycles == 4000)
   begin
      fails = fails + 1;
      summarize;
   end
end
task summarize;
begin
   $display("compares %0d fails %0d", compares, fails);
   if (fails == 0 && compares > 0)
      $display("verification passed");
   else
      $display("verification failed");
   $finish;
end
endtask
task check(input [31:0] got, input [31:0] exp);
begin
   compares = compares + 1;
   if (got !== exp)
   begin
      fails = fails + 1;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
   end
end
endtask
// entered just after an edge; waits for ack with no assumed latency
task wb(input w, input [7:0] a, input [31:0] dv, input s);
begin
   wb_cyc_i <= 1'b1;
   wb_stb_i <= 1'b1;
   wb_we_i <= w;
   wb_adr_i <= a;
   wb_dat_i <= dv;
   wb_sel_i <= {3'h0, s};
   do
      @(posedge clk);
   while (wb_ack_o !== 1'b1);
   rd = wb_dat_o;
   wb_cyc_i <= 1'b0;
   wb_stb_i <= 1'b0;
   @(posedge clk);
end
endtask
task model;
integer n;
begin
   io = {m_osc == 5 || m_osc == 6, m_osc == 4 || m_osc == 6 || m_osc == 8, 6'h3f};
   ck = (m_osc == 3 || m_osc == 5 || m_osc == 7) ? 8'h40 : 8'h00;
   e_an = 8'h00;
   for (n = 0; n < 6; n = n + 1)
      e_an[n] = (n < 4 && m_cmp[2:0] != 3'h7) || (n != 4 && m_anc[3:0] + (n == 5 ? 4 : n) <= 14);
   e_oe = (~m_dir[7:0] & io) | ck;
   e_oe[2] = e_oe[2] & !m_cvr[6];
   e_out = m_lat[7:0];
   if (m_cmp[2:0] == 3'h3)
      e_out[4] = comparator_one_output;
   if (m_cmp[2:0] == 3'h3 || m_cmp[2:0] == 3'h5)
      e_out[5] = comparator_two_output;
end
endtask
function [31:0] exp_rd(input [7:0] a);
begin
   case (a)
      `GPA_OFS_PORT: exp_rd = {24'h0, pad_in & io & ~e_an & ~{5'h0, m_cvr[6], 2'h0}};
      `GPA_OFS_LATCH: exp_rd = m_lat & io;
      `GPA_OFS_DIR: exp_rd = m_dir & io;
      `GPA_OFS_ANCFG: exp_rd = m_anc;
      `GPA_OFS_CMPCTL: exp_rd = {comparator_two_output, comparator_one_output, m_cmp[5:0]};
      `GPA_OFS_CVRCTL: exp_rd = m_cvr;
      `GPA_OFS_OSCCFG: exp_rd = m_osc;
      default: exp_rd = 32'h0;
   endcase
end
endfunction
task wr(input [7:0] a, input [31:0] dv, input s);
begin
   wb(1'b1, a, dv, s);
   if (s)
      case (a)
         `GPA_OFS_PORT, `GPA_OFS_LATCH: m_lat = dv[7:0];
         `GPA_OFS_DIR: m_dir = dv[7:0];
         `GPA_OFS_ANCFG: m_anc = dv[5:0];
         `GPA_OFS_CMPCTL: m_cmp = dv[5:0];
         `GPA_OFS_CVRCTL: m_cvr = dv[7:0];
         `GPA_OFS_OSCCFG: m_osc = dv[3:0];
         default: ;
      endcase
   model;
   check({analog_sel, pad_oe, pad_out & e_oe & ~ck}, {e_an, e_oe, e_out & e_oe & ~ck});
end
endtask
task rc(input [7:0] a);
begin
   wb(1'b0, a, 32'h0, 1'b0);
   model;
   check(rd, exp_rd(a));
end
endtask
task reset_run;
begin
   resetn <= 1'b0;
   repeat (3) @(posedge clk);
   resetn <= 1'b1;
   @(posedge clk);
   m_lat = 0;
   m_dir = 255;
   m_anc = 0;
   m_cmp = 7;
   m_cvr = 0;
   m_osc = 6;
   for (i = 0; i < 9; i = i + 1)
      rc(8'(4 * i));
   check({analog_sel, pad_oe}, {e_an, e_oe});
   $display("reset test done");
end
endtask
// ----------------
// main sequence
// ----------------
initial
begin
   void'($urandom(32'hdcdc));
   reset_run;
   wr(`GPA_OFS_LATCH, $urandom, 1'b1);
   wr(`GPA_OFS_DIR, 32'h0, 1'b1);
   for (i = 0; i < 9; i = i + 1)
   begin
      ext <= 8'($urandom);
      wr(`GPA_OFS_DIR, i[0] ? 32'hff : 32'h0, 1'b1);
      wr(`GPA_OFS_OSCCFG, i, 1'b1);
      rc(`GPA_OFS_PORT);
      rc(`GPA_OFS_LATCH);
      rc(`GPA_OFS_DIR);
      for (j = 0; j < 8; j = j + 1)
      begin
         @(posedge clk);
         cs[j] = pad_out[6];
      end
      if (ck[6])
         check({26'h0, cs[7:2]}, {26'h0, ~cs[5:0]});
   end
   $display("oscillator test done");
   wr(`GPA_OFS_ANCFG, 32'hff, 1'b1);
   for (i = 0; i < 16; i = i + 1)
   begin
      comparator_one_output <= 1'($urandom);
      comparator_two_output <= 1'($urandom);
      ext <= 8'($urandom);
      d = $urandom;
      d[2:0] = i[2:0];
      wr(`GPA_OFS_CMPCTL, d, 1'b1);
      wr(`GPA_OFS_CVRCTL, i[3] ? 32'h40 : 32'h0, 1'b1);
      wr(`GPA_OFS_DIR, $urandom, 1'b1);
      rc(`GPA_OFS_PORT);
      rc(`GPA_OFS_CMPCTL);
   end
   $display("comparator test done");
   for (i = 0; i < 60; i = i + 1)
   begin
      ext <= 8'($urandom);
      comparator_one_output <= 1'($urandom);
      d = $urandom;
      j = $urandom % 8;
      if (j == 6)
         d = d % 9;
      wr(8'(4 * j), d, 1'($urandom));
      rc(8'(4 * ($urandom % 8)));
   end
   $display("random test done");
   reset_run;
   summarize;
end
endmodule
